// [rtl/seoc_top.sv]
// Exposure, gain and output control with serial register port.
// Assumes CLK for the serial port and LINK_CLK for video timing,
// which also carries the field and line events.
//
// Notes on behaviour
// - Embedded sequences off suppresses field start strobe; line start strobe unchanged.
// - Embedded sequences off: qualified clock runs only if free-running chosen.
// - Data outputs driven only when tri-state bit and disable pin are both 0.
// - With retime set, new tri-state settings apply only at field boundary.
// - Config bit 0, reset 1, selects line arrangement for default coprocessor.
// - Retro gain: current DAC is inverted low nibble; high nibble writes ignored.
// - Config bit 2 set varies capacitor DAC along logarithmic ramp per line.
// - Exposure, gain and divisor writes are held and applied at field start.
// - Exposure values above range clip to limits from line and field length.
// - Fine maximum is line length minus 51, 86 or 23 by mode.
// - Coarse resets to 302; maximum 260, 310, 318 or 158 by mode.
// - Gain resets to F0; upper nibble capacitor DAC, lower nibble current DAC.
// - Capacitor DAC default is 63 in ten-bit, 31 in nine-bit modes.
// - Four-bit clock divisor, reset 0, slows internal clocks.
// - Pixel clock division ratio is divisor setting plus one.
`timescale 1ns/1ps
`include "seoc_defs.svh"

module seoc_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic LINK_CLK,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic OEB,
  input wire logic FIELD_START_EVT,
  input wire logic LINE_START_EVT,
  input wire logic [1:0] VIDEO_MODE,
  input wire logic [9:0] LINE_LENGTH,
  input wire logic TEN_BIT_MODE,
  input wire logic QCK_FREE_RUN,
  output logic DATA_OE,
  output logic STROBE_OE,
  output logic QCK_OE,
  output logic FIELD_START_STROBE,
  output logic LINE_START_STROBE,
  output logic QCK_ENABLE,
  output logic LINE_ARRANGE_SEL,
  output logic [8:0] FINE_EXPOSURE,
  output logic [8:0] COARSE_EXPOSURE,
  output logic [5:0] CAP_GAIN_DAC,
  output logic [3:0] CUR_GAIN_DAC,
  output logic CLK_DIV_TICK
);

  // ----------------------------------------------------------------
  // Serial pins
  // ----------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;

  seoc_sync #(.RST_VAL(1'b1)) u_sync_scl (.clk(CLK), .arst_n(ARST_N), .din(SCL), .dout(scl_s));
  seoc_sync #(.RST_VAL(1'b1)) u_sync_sda (.clk(CLK), .arst_n(ARST_N), .din(SDA_IN), .dout(sda_s));

  // Previous settled levels for edge detection
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  seoc_pkg::seoc_ser_e st;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic byte_full;
  logic rw;
  logic nack;
  logic [7:0] index;
  logic wr_stb;
  logic [7:0] rd_data;

  wire addr_match = (shreg[7:1] == `SEOC_DEV_ADDR);
  wire shift_st = |(st & 9'h0AA); // Acks and idle shift nothing

  // Bytes shift in on SCL rise; SDA changes only on SCL fall
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= seoc_pkg::SEOC_SER_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 3'h0;
      byte_full <= 1'b0;
      rw <= 1'b0;
      nack <= 1'b0;
      index <= 8'h00;
      wr_stb <= 1'b0;
      SDA_OE <= 1'b0;
      SDA_OUT <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        st <= seoc_pkg::SEOC_SER_ADDR;
        bit_cnt <= 3'h0;
        byte_full <= 1'b0;
        SDA_OE <= 1'b0;
      end else if (bus_stop) begin
        st <= seoc_pkg::SEOC_SER_IDLE;
        SDA_OE <= 1'b0;
      end else if (scl_rise) begin
        if (st == seoc_pkg::SEOC_SER_RDATA_ACK) begin
          nack <= sda_s;
        end else if (shift_st && !byte_full) begin
          shreg <= {shreg[6:0], sda_s};
          bit_cnt <= bit_cnt + 3'h1;
          byte_full <= (bit_cnt == 3'h7);
        end
      end else if (scl_fall) begin
        case (st)
          seoc_pkg::SEOC_SER_ADDR: begin
            if (byte_full) begin
              byte_full <= 1'b0;
              rw <= shreg[0];
              SDA_OE <= addr_match;
              st <= addr_match ? seoc_pkg::SEOC_SER_ADDR_ACK : seoc_pkg::SEOC_SER_IDLE;
            end
          end
          seoc_pkg::SEOC_SER_ADDR_ACK: begin
            if (rw) begin
              shreg <= rd_data;
              SDA_OE <= ~rd_data[7];
              st <= seoc_pkg::SEOC_SER_RDATA;
            end else begin
              SDA_OE <= 1'b0;
              st <= seoc_pkg::SEOC_SER_INDEX;
            end
          end
          seoc_pkg::SEOC_SER_INDEX: begin
            if (byte_full) begin
              byte_full <= 1'b0;
              index <= shreg;
              SDA_OE <= 1'b1;
              st <= seoc_pkg::SEOC_SER_INDEX_ACK;
            end
          end
          seoc_pkg::SEOC_SER_WDATA: begin
            if (byte_full) begin
              byte_full <= 1'b0;
              wr_stb <= 1'b1;
              SDA_OE <= 1'b1;
              st <= seoc_pkg::SEOC_SER_WDATA_ACK;
            end
          end
          seoc_pkg::SEOC_SER_INDEX_ACK, seoc_pkg::SEOC_SER_WDATA_ACK: begin
            if (st == seoc_pkg::SEOC_SER_WDATA_ACK) begin
              index <= index + 8'h01;
            end
            SDA_OE <= 1'b0;
            st <= seoc_pkg::SEOC_SER_WDATA;
          end
          seoc_pkg::SEOC_SER_RDATA: begin
            // Bit 7 already on the line; shift after each rise
            if (byte_full) begin
              byte_full <= 1'b0;
              index <= index + 8'h01;
              SDA_OE <= 1'b0;
              st <= seoc_pkg::SEOC_SER_RDATA_ACK;
            end else begin
              SDA_OE <= ~shreg[7];
            end
          end
          seoc_pkg::SEOC_SER_RDATA_ACK: begin
            shreg <= rd_data;
            SDA_OE <= ~nack & ~rd_data[7];
            st <= nack ? seoc_pkg::SEOC_SER_IDLE : seoc_pkg::SEOC_SER_RDATA;
          end
          default: begin
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] data_fmt;
  logic [7:0] out_fmt;
  logic [2:0] op_cfg;
  logic fine_hi;
  logic coarse_hi;
  logic [8:0] fine_exp;
  logic [8:0] coarse_exp;
  logic [7:0] gain;
  logic [3:0] clk_div;

  wire [7:0] wdat = shreg;
  wire retro = op_cfg[`SEOC_CFG_RETRO_GAIN];

  // High exposure bytes wait for their low byte so a pair commits as one
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      data_fmt <= `SEOC_RST_DATA_FORMAT;
      out_fmt <= `SEOC_RST_OUTPUT_FORMAT;
      op_cfg <= `SEOC_RST_OPERATING_CONFIG;
      fine_hi <= 1'b0;
      coarse_hi <= 1'(`SEOC_RST_COARSE_EXPOSURE >> 8);
      fine_exp <= `SEOC_RST_FINE_EXPOSURE;
      coarse_exp <= `SEOC_RST_COARSE_EXPOSURE;
      gain <= `SEOC_RST_ANALOG_GAIN;
      clk_div <= `SEOC_RST_CLOCK_DIVISOR;
    end else if (wr_stb) begin
      case (index)
        `SEOC_IDX_DATA_FORMAT: data_fmt <= wdat & 8'h60;
        `SEOC_IDX_OUTPUT_FORMAT: out_fmt <= (wdat & 8'h67) | 8'h18;
        `SEOC_IDX_OPERATING_CONFIG: op_cfg <= wdat[2:0];
        `SEOC_IDX_FINE_EXPOSURE_HIGH: fine_hi <= wdat[0];
        `SEOC_IDX_FINE_EXPOSURE_LOW: fine_exp <= {fine_hi, wdat};
        `SEOC_IDX_COARSE_EXPOSURE_HIGH: coarse_hi <= wdat[0];
        `SEOC_IDX_COARSE_EXPOSURE_LOW: coarse_exp <= {coarse_hi, wdat};
        `SEOC_IDX_ANALOG_GAIN: gain <= retro ? {gain[7:4], wdat[3:0]} : wdat;
        `SEOC_IDX_CLOCK_DIVISOR: clk_div <= wdat[3:0];
        default: ;
      endcase
    end
  end

  // Read mux; control bits read back at once, before any retiming
  assign rd_data = (index == `SEOC_IDX_DATA_FORMAT) ? data_fmt :
                   (index == `SEOC_IDX_OUTPUT_FORMAT) ? out_fmt :
                   (index == `SEOC_IDX_OPERATING_CONFIG) ? {5'h00, op_cfg} :
                   (index == `SEOC_IDX_FINE_EXPOSURE_HIGH) ? {7'h00, fine_hi} :
                   (index == `SEOC_IDX_FINE_EXPOSURE_LOW) ? fine_exp[7:0] :
                   (index == `SEOC_IDX_COARSE_EXPOSURE_HIGH) ? {7'h00, coarse_hi} :
                   (index == `SEOC_IDX_COARSE_EXPOSURE_LOW) ? coarse_exp[7:0] :
                   (index == `SEOC_IDX_ANALOG_GAIN) ? gain :
                   (index == `SEOC_IDX_CLOCK_DIVISOR) ? {4'h0, clk_div} : 8'h00;

  // ----------------------------------------------------------------
  // Crossing to the link domain
  // ----------------------------------------------------------------
  localparam int BW = 45;
  wire [BW-1:0] bundle = {out_fmt[`SEOC_FMT_RETIME], out_fmt[`SEOC_FMT_EMBED_OFF],
                          out_fmt[`SEOC_FMT_DATA_TRI], data_fmt[`SEOC_DFMT_STROBE_TRI],
                          data_fmt[`SEOC_DFMT_QCK_TRI], op_cfg, fine_exp, coarse_exp,
                          gain, clk_div, 7'h00};
  logic [BW-1:0] snap;
  logic req_tgl;
  logic ack_s;
  logic dirty;

  wire busy = req_tgl ^ ack_s;
  wire launch = dirty & ~busy;

  // Snapshot stays still until the link side hands back the toggle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      snap <= '0;
      req_tgl <= 1'b0;
      dirty <= 1'b1;
    end else begin
      dirty <= wr_stb | (dirty & ~launch);
      if (launch) begin
        snap <= bundle;
        req_tgl <= ~req_tgl;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link domain: take over new settings
  // ----------------------------------------------------------------
  logic req_s;
  logic req_seen;
  logic ack_tgl;
  logic got;
  logic [BW-1:0] rx;

  seoc_sync u_sync_req (.clk(LINK_CLK), .arst_n(ARST_N), .din(req_tgl), .dout(req_s));
  seoc_sync u_sync_ack (.clk(CLK), .arst_n(ARST_N), .din(ack_tgl), .dout(ack_s));

  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      got <= 1'b0;
      rx <= '0;
    end else if (req_s != req_seen) begin
      req_seen <= req_s;
      ack_tgl <= req_s;
      got <= 1'b1;
      rx <= snap;
    end
  end

  // Until the first snapshot arrives the reset values stand
  wire rx_retime = got & rx[44];
  wire rx_embed_off = got & rx[43];
  wire [2:0] rx_tri = got ? rx[42:40] : 3'h0;
  wire [2:0] rx_cfg = got ? rx[39:37] : `SEOC_RST_OPERATING_CONFIG;
  wire [8:0] rx_fine = got ? rx[36:28] : `SEOC_RST_FINE_EXPOSURE;
  wire [8:0] rx_coarse = got ? rx[27:19] : `SEOC_RST_COARSE_EXPOSURE;
  wire [7:0] rx_gain = got ? rx[18:11] : `SEOC_RST_ANALOG_GAIN;
  wire [3:0] rx_div = got ? rx[10:7] : `SEOC_RST_CLOCK_DIVISOR;

  // ----------------------------------------------------------------
  // Field-synchronous apply and clipping
  // ----------------------------------------------------------------
  wire [9:0] fine_ofs = (VIDEO_MODE == seoc_pkg::SEOC_MODE_PAL) ? `SEOC_FINE_OFS_PAL :
                        (VIDEO_MODE == seoc_pkg::SEOC_MODE_QCIF) ? `SEOC_FINE_OFS_QCIF :
                        `SEOC_FINE_OFS_NTSC_CIF;
  wire [9:0] fine_lim = (LINE_LENGTH > fine_ofs) ? (LINE_LENGTH - fine_ofs) : 10'h000;
  wire [8:0] fine_max = fine_lim[9] ? 9'h1FF : fine_lim[8:0];
  wire [8:0] coarse_max = (VIDEO_MODE == seoc_pkg::SEOC_MODE_NTSC) ? `SEOC_COARSE_MAX_NTSC :
                          (VIDEO_MODE == seoc_pkg::SEOC_MODE_PAL) ? `SEOC_COARSE_MAX_PAL :
                          (VIDEO_MODE == seoc_pkg::SEOC_MODE_CIF) ? `SEOC_COARSE_MAX_CIF :
                          `SEOC_COARSE_MAX_QCIF;
  wire [8:0] fine_clip = (rx_fine > fine_max) ? fine_max : rx_fine;
  wire [8:0] coarse_clip = (rx_coarse > coarse_max) ? coarse_max : rx_coarse;

  logic [2:0] tri_app;
  logic [7:0] gain_app;
  logic [3:0] div_app;

  // Whole exposure set moves together at field start
  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FINE_EXPOSURE <= `SEOC_RST_FINE_EXPOSURE;
      COARSE_EXPOSURE <= `SEOC_RST_COARSE_EXPOSURE;
      gain_app <= `SEOC_RST_ANALOG_GAIN;
      div_app <= `SEOC_RST_CLOCK_DIVISOR;
      tri_app <= 3'h0;
    end else begin
      if (FIELD_START_EVT) begin
        FINE_EXPOSURE <= fine_clip;
        COARSE_EXPOSURE <= coarse_clip;
        gain_app <= rx_gain;
        div_app <= rx_div;
      end
      if (!rx_retime || FIELD_START_EVT) begin
        tri_app <= rx_tri;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output enables and strobes
  // ----------------------------------------------------------------
  logic oeb_s;

  seoc_sync #(.RST_VAL(1'b1)) u_sync_oeb (.clk(LINK_CLK), .arst_n(ARST_N), .din(OEB), .dout(oeb_s));

  // Each enable is the inverse of its tri-state bit OR the pin
  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DATA_OE <= 1'b0;
      STROBE_OE <= 1'b0;
      QCK_OE <= 1'b0;
      FIELD_START_STROBE <= 1'b0;
      LINE_START_STROBE <= 1'b0;
      QCK_ENABLE <= 1'b0;
      LINE_ARRANGE_SEL <= 1'b1;
    end else begin
      DATA_OE <= ~(tri_app[2] | oeb_s);
      STROBE_OE <= ~(tri_app[1] | oeb_s);
      QCK_OE <= ~(tri_app[0] | oeb_s);
      FIELD_START_STROBE <= FIELD_START_EVT & ~rx_embed_off;
      LINE_START_STROBE <= LINE_START_EVT;
      QCK_ENABLE <= ~rx_embed_off | QCK_FREE_RUN;
      LINE_ARRANGE_SEL <= rx_cfg[`SEOC_CFG_COPROC_DEFAULT];
    end
  end

  // ----------------------------------------------------------------
  // Gain DACs and logarithmic ramp
  // ----------------------------------------------------------------
  wire [5:0] capacitor_gain_dac_base = TEN_BIT_MODE ? {gain_app[7:4], `SEOC_CAPACITOR_GAIN_DAC_LOW_BITS} :
                         {1'b0, gain_app[7:5], `SEOC_CAPACITOR_GAIN_DAC_LOW_BITS};
  logic [5:0] ramp_val;
  logic [7:0] seg_len;
  logic [7:0] seg_cnt;

  // Each ramp step's count limit doubles up to SEOC_RAMP_SEG_MAX, then holds, so the value falls log-like
  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ramp_val <= 6'h00;
      seg_len <= 8'h01;
      seg_cnt <= 8'h00;
    end else if (LINE_START_EVT) begin
      ramp_val <= capacitor_gain_dac_base;
      seg_len <= 8'h01;
      seg_cnt <= 8'h00;
    end else if (seg_cnt == seg_len) begin
      seg_cnt <= 8'h00;
      seg_len <= (seg_len == `SEOC_RAMP_SEG_MAX) ? seg_len : {seg_len[6:0], 1'b0};
      ramp_val <= (ramp_val == 6'h00) ? ramp_val : ramp_val - 6'h01;
    end else begin
      seg_cnt <= seg_cnt + 8'h01;
    end
  end

  // DAC outputs; retro mode inverts the low nibble
  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CAP_GAIN_DAC <= {4'hF, `SEOC_CAPACITOR_GAIN_DAC_LOW_BITS};
      CUR_GAIN_DAC <= 4'h0;
    end else begin
      CAP_GAIN_DAC <= rx_cfg[`SEOC_CFG_LOG_RAMP] ? ramp_val : capacitor_gain_dac_base;
      CUR_GAIN_DAC <= rx_cfg[`SEOC_CFG_RETRO_GAIN] ? ~gain_app[3:0] : gain_app[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Pixel clock divider
  // ----------------------------------------------------------------
  logic [3:0] div_cnt;

  // One tick every setting-plus-one link cycles
  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_cnt <= 4'h0;
      CLK_DIV_TICK <= 1'b0;
    end else begin
      CLK_DIV_TICK <= (div_cnt == div_app);
      div_cnt <= (div_cnt == div_app) ? 4'h0 : div_cnt + 4'h1;
    end
  end

endmodule : seoc_top

// [rtl/seoc_defs.svh]
// Offsets, fields, resets and limits of the exposure block.
// Included by the top module and the bench; definitions only.
`ifndef SEOC_DEFS_SVH
`define SEOC_DEFS_SVH

// Register indices
`define SEOC_IDX_DATA_FORMAT 8'h16
`define SEOC_IDX_OUTPUT_FORMAT 8'h17
`define SEOC_IDX_OPERATING_CONFIG 8'h18
`define SEOC_IDX_FINE_EXPOSURE_HIGH 8'h20
`define SEOC_IDX_FINE_EXPOSURE_LOW 8'h21
`define SEOC_IDX_COARSE_EXPOSURE_HIGH 8'h22
`define SEOC_IDX_COARSE_EXPOSURE_LOW 8'h23
`define SEOC_IDX_ANALOG_GAIN 8'h24
`define SEOC_IDX_CLOCK_DIVISOR 8'h25

// Field positions
`define SEOC_FMT_EMBED_OFF 2
`define SEOC_FMT_DATA_TRI 5
`define SEOC_FMT_RETIME 6
`define SEOC_DFMT_STROBE_TRI 5
`define SEOC_DFMT_QCK_TRI 6
`define SEOC_CFG_COPROC_DEFAULT 0
`define SEOC_CFG_RETRO_GAIN 1
`define SEOC_CFG_LOG_RAMP 2

// Reset values
`define SEOC_RST_DATA_FORMAT 8'h00
`define SEOC_RST_OUTPUT_FORMAT 8'h18
`define SEOC_RST_OPERATING_CONFIG 3'h1
`define SEOC_RST_FINE_EXPOSURE 9'h000
`define SEOC_RST_COARSE_EXPOSURE 9'h12E
`define SEOC_RST_ANALOG_GAIN 8'hF0
`define SEOC_RST_CLOCK_DIVISOR 4'h0

// Fine offsets per mode
`define SEOC_FINE_OFS_NTSC_CIF 10'h033
`define SEOC_FINE_OFS_PAL 10'h056
`define SEOC_FINE_OFS_QCIF 10'h017

// Coarse maxima per mode
`define SEOC_COARSE_MAX_NTSC 9'h104
`define SEOC_COARSE_MAX_PAL 9'h136
`define SEOC_COARSE_MAX_CIF 9'h13E
`define SEOC_COARSE_MAX_QCIF 9'h09E

// Cap DAC low bits, ramp step cap
`define SEOC_CAPACITOR_GAIN_DAC_LOW_BITS 2'h3
`define SEOC_RAMP_SEG_MAX 8'h80

// Serial interface device address (arbitrary value)
`define SEOC_DEV_ADDR 7'h2A

`endif

// [rtl/seoc_pkg.sv]
// Types of the exposure block.
// Does not need seoc_defs.svh on the include path.
package seoc_pkg;

  // Video mode selected by the timing logic
  typedef enum logic [1:0] {
    SEOC_MODE_NTSC = 2'h0,
    SEOC_MODE_PAL = 2'h1,
    SEOC_MODE_CIF = 2'h2,
    SEOC_MODE_QCIF = 2'h3
  } seoc_mode_e;

  // Serial slave states, one-hot
  typedef enum logic [8:0] {
    SEOC_SER_IDLE = 9'h001,
    SEOC_SER_ADDR = 9'h002,
    SEOC_SER_ADDR_ACK = 9'h004,
    SEOC_SER_INDEX = 9'h008,
    SEOC_SER_INDEX_ACK = 9'h010,
    SEOC_SER_WDATA = 9'h020,
    SEOC_SER_WDATA_ACK = 9'h040,
    SEOC_SER_RDATA = 9'h080,
    SEOC_SER_RDATA_ACK = 9'h100
  } seoc_ser_e;

endpackage : seoc_pkg

// [rtl/seoc_sync.sv]
// Three-stage level synchroniser.
// The output moves only once the second and third stages agree.
`timescale 1ns/1ps

module seoc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);

  logic s1;
  logic s2;
  logic s3;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end

endmodule : seoc_sync

// [bench/seoc_top_assertions.sv]
// Link-side checks on the top's outputs.
// Bound from the bench top file; sees only top-level ports.
`timescale 1ns/1ps
module seoc_chk (
  input wire logic LINK_CLK,
  input wire logic ARST_N,
  input wire logic OEB,
  input wire logic FIELD_START_EVT,
  input wire logic LINE_START_EVT,
  input wire logic [1:0] VIDEO_MODE,
  input wire logic [9:0] LINE_LENGTH,
  input wire logic DATA_OE,
  input wire logic FIELD_START_STROBE,
  input wire logic LINE_START_STROBE,
  input wire logic [8:0] FINE_EXPOSURE,
  input wire logic [8:0] COARSE_EXPOSURE,
  input wire logic [3:0] CUR_GAIN_DAC,
  input wire logic CLK_DIV_TICK
);
  // ----------------------------------------
  // Link domain properties
  // ----------------------------------------
  default clocking cb @(posedge LINK_CLK); endclocking
  default disable iff (!ARST_N);
  // Pin must outlast the synchroniser and the output register
  sequence s_oeb_held;
    OEB[*7];
  endsequence
  property p_oeb;
    s_oeb_held |-> !DATA_OE;
  endproperty
  a_oeb: assert property (p_oeb) else $error("data bus driven with disable pin high");
  property p_fst;
    FIELD_START_STROBE |-> $past(FIELD_START_EVT);
  endproperty
  a_fst: assert property (p_fst) else $error("field strobe without field event");
  property p_lst;
    LINE_START_EVT |=> LINE_START_STROBE;
  endproperty
  a_lst: assert property (p_lst) else $error("line strobe missing");
  // Exposure moves only after a field event
  property p_hold;
    ($changed(FINE_EXPOSURE) || $changed(COARSE_EXPOSURE))
      |-> ($past(FIELD_START_EVT) || $past(FIELD_START_EVT, 2));
  endproperty
  a_hold: assert property (p_hold) else $error("exposure changed off field event");
  property p_coarse;
    FIELD_START_EVT && VIDEO_MODE == 2'h0 |-> ##2 COARSE_EXPOSURE <= 9'h104;
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse above NTSC limit");
  property p_fine;
    FIELD_START_EVT && VIDEO_MODE == 2'h1 |-> ##2 (FINE_EXPOSURE == 9'h000 ||
      {1'b0, FINE_EXPOSURE} + 10'h056 <= $past(LINE_LENGTH, 2));
  endproperty
  a_fine: assert property (p_fine) else $error("fine above PAL limit");
  property p_rst;
    $rose(ARST_N) |-> COARSE_EXPOSURE == 9'h12E && FINE_EXPOSURE == 9'h000 && CUR_GAIN_DAC == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("wrong exposure reset values");
  // Ratio up to 16; a change may stretch one gap
  property p_tick;
    !CLK_DIV_TICK[*8] |-> ##[0:24] CLK_DIV_TICK;
  endproperty
  a_tick: assert property (p_tick) else $error("divided tick missing");
endmodule : seoc_chk

// [bench/seoc_coproc_model.sv]
// Coprocessor side: line/field events, strobe counts, tick gap.
// Field events only on request.
`timescale 1ns/1ps
module seoc_coproc_model (
  input wire logic lclk,
  input wire logic arst_n,
  input wire logic field_start_strobe,
  input wire logic line_start_strobe,
  input wire logic tick,
  output logic field_evt,
  output logic line_evt
);
  int fst_cnt = 0;
  int lst_cnt = 0;
  int gap = 0;
  int run = 0;
  int lcnt = 0;
  initial field_evt = 1'b0;
  // Line events every 24 link cycles, none during reset
  always @(posedge lclk) begin
    lcnt <= (lcnt == 23) ? 0 : lcnt + 1;
    line_evt <= arst_n && lcnt == 23;
    if (field_start_strobe) fst_cnt <= fst_cnt + 1;
    if (line_start_strobe) lst_cnt <= lst_cnt + 1;
    run <= tick ? 1 : run + 1;
    if (tick) gap <= run;
  end
  task automatic field();
    @(posedge lclk) field_evt <= 1'b1;
    @(posedge lclk) field_evt <= 1'b0;
  endtask : field
endmodule : seoc_coproc_model

// [bench/test_seoc_top.sv]
// Self-checking bench: serial master and model of applied values.
// Needs seoc_defs.svh on the include path.
`timescale 1ns/1ps
`include "seoc_defs.svh"
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); \
  end \
end
module test_seoc_top;
  logic CLK = 1'b0;
  logic LINK_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic SCL = 1'b1;
  logic sda_m = 1'b1;
  logic OEB = 1'b0;
  logic TEN_BIT_MODE = 1'b1;
  logic QCK_FREE_RUN = 1'b0;
  logic [1:0] VIDEO_MODE = 2'h0;
  logic [9:0] LINE_LENGTH = 10'h19F;
  logic SDA_IN, SDA_OUT, SDA_OE, DATA_OE, STROBE_OE, QCK_OE, FIELD_START_STROBE;
  logic LINE_START_STROBE, QCK_ENABLE, LINE_ARRANGE_SEL, CLK_DIV_TICK;
  logic FIELD_START_EVT, LINE_START_EVT;
  logic [8:0] FINE_EXPOSURE, COARSE_EXPOSURE;
  logic [5:0] CAP_GAIN_DAC;
  logic [3:0] CUR_GAIN_DAC;
  int bad_count = 0;
  int cmp_count = 0;
  // ----------------------------------------
  // Model state and helpers
  // ----------------------------------------
  logic [8:0] rf = 9'h000, rc = 9'h12E, ef = 9'h000, ec = 9'h12E, nf, nc;
  logic [7:0] g = 8'hF0;
  logic retro = 1'b0;
  logic embed = 1'b1;
  int e_fst = 0;
  int d, l, mx;
  logic [9:0] fo[4] = '{`SEOC_FINE_OFS_NTSC_CIF, `SEOC_FINE_OFS_PAL,
                        `SEOC_FINE_OFS_NTSC_CIF, `SEOC_FINE_OFS_QCIF};
  logic [8:0] cm[4] = '{`SEOC_COARSE_MAX_NTSC, `SEOC_COARSE_MAX_PAL,
                        `SEOC_COARSE_MAX_CIF, `SEOC_COARSE_MAX_QCIF};
  // Open drain, pulled up
  assign SDA_IN = SDA_OE ? 1'b0 : sda_m;
  always #2.5 CLK = ~CLK;
  initial begin
    #1.3;
    forever #15 LINK_CLK = ~LINK_CLK;
  end
  seoc_top DUT (.*);
  seoc_coproc_model cp (.lclk(LINK_CLK), .arst_n(ARST_N), .field_start_strobe(FIELD_START_STROBE),
    .line_start_strobe(LINE_START_STROBE), .tick(CLK_DIV_TICK), .field_evt(FIELD_START_EVT),
    .line_evt(LINE_START_EVT));
  task automatic wt(input int n);
    repeat (n) @(negedge CLK);
  endtask : wt
  // Ends on a CLK fall
  task automatic wlk(input int n);
    repeat (n) @(negedge LINK_CLK);
    @(negedge CLK);
  endtask : wlk
  // SDA moves mid-low to keep pin order
  task automatic sbit(input logic b);
    sda_m = b;
    wt(6);
    SCL = 1'b1;
    wt(8);
    SCL = 1'b0;
    wt(2);
  endtask : sbit
  task automatic sbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) sbit(b[i]);
    sda_m = 1'b1;
    wt(6);
    SCL = 1'b1;
    wt(4);
    `CHK("ack", 1'b0, SDA_IN)
    wt(4);
    SCL = 1'b0;
    wt(2);
  endtask : sbyte
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    sda_m = 1'b0;
    wt(6);
    SCL = 1'b0;
    wt(2);
    sbyte({`SEOC_DEV_ADDR, 1'b0});
    sbyte(idx);
    sbyte(v);
    sda_m = 1'b0;
    wt(4);
    SCL = 1'b1;
    wt(6);
    sda_m = 1'b1;
    wt(6);
  endtask : wr
  // Field event: held before, clipped after
  task automatic fld();
    wlk(10);
    `CHK("fine held", ef, FINE_EXPOSURE)
    `CHK("coarse held", ec, COARSE_EXPOSURE)
    cp.field();
    wlk(4);
    mx = int'(LINE_LENGTH) - int'(fo[VIDEO_MODE]);
    mx = (mx < 0) ? 0 : ((mx > 511) ? 511 : mx);
    ef = (int'(rf) > mx) ? 9'(mx) : rf;
    ec = (rc > cm[VIDEO_MODE]) ? cm[VIDEO_MODE] : rc;
    if (embed) e_fst++;
    `CHK("fine", ef, FINE_EXPOSURE)
    `CHK("coarse", ec, COARSE_EXPOSURE)
    `CHK("cur dac", retro ? ~g[3:0] : g[3:0], CUR_GAIN_DAC)
    `CHK("cap dac", TEN_BIT_MODE ? {g[7:4], 2'h3} : {1'b0, g[7:5], 2'h3}, CAP_GAIN_DAC)
    `CHK("fst count", e_fst, cp.fst_cnt)
  endtask : fld
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(56606));
    repeat (6) @(negedge LINK_CLK);
    @(negedge CLK);
    ARST_N = 1'b1;
    wlk(10);
    `CHK("arrange", 1'b1, LINE_ARRANGE_SEL)
    `CHK("div gap", 1, cp.gap)
    fld();
    wr(8'h18, 8'h00);
    wlk(10);
    `CHK("arrange", 1'b0, LINE_ARRANGE_SEL)
    // Lone high bytes must not land
    for (int m = 0; m < 4; m++) begin
      VIDEO_MODE = 2'(m);
      LINE_LENGTH = 10'(200 + $urandom_range(400));
      nf = 9'($urandom_range(511));
      nc = (m == 1) ? 9'h1FF : 9'($urandom_range(511));
      wr(8'h20, {7'h00, nf[8]});
      wr(8'h22, {7'h00, nc[8]});
      fld();
      wr(8'h21, nf[7:0]);
      wr(8'h23, nc[7:0]);
      rf = nf;
      rc = nc;
      fld();
    end
    g = {4'($urandom_range(15)), 4'($urandom_range(12))};
    wr(8'h24, g);
    fld();
    TEN_BIT_MODE = 1'b0;
    fld();
    TEN_BIT_MODE = 1'b1;
    wr(8'h18, 8'h03);
    retro = 1'b1;
    wr(8'h24, {~g[7:4], 4'h5});
    g[3:0] = 4'h5;
    fld();
    wr(8'h18, 8'h05);
    retro = 1'b0;
    wlk(10);
    for (d = 0; d < 60 && LINE_START_EVT !== 1'b1; d++) @(posedge LINK_CLK);
    if (d == 60) begin
      bad_count++;
      conclude();
    end
    wlk(4);
    `CHK("ramp", 1'b1, CAP_GAIN_DAC < {g[7:4], 2'h3})
    wr(8'h18, 8'h01);
    wlk(30);
    `CHK("flat", {g[7:4], 2'h3}, CAP_GAIN_DAC)
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 15 : $urandom_range(14);
      wr(8'h25, 8'(d));
      fld();
      wlk(40);
      `CHK("div gap", d + 1, cp.gap)
    end
    OEB = 1'b1;
    wlk(10);
    `CHK("oe pin", 3'h0, {DATA_OE, STROBE_OE, QCK_OE})
    OEB = 1'b0;
    wlk(10);
    `CHK("oe pin", 3'h7, {DATA_OE, STROBE_OE, QCK_OE})
    wr(8'h17, 8'h38);
    wlk(10);
    `CHK("oe bit", 1'b0, DATA_OE)
    wr(8'h17, 8'h58);
    wlk(10);
    `CHK("retimed", 1'b0, DATA_OE)
    fld();
    `CHK("retimed", 1'b1, DATA_OE)
    wr(8'h17, 8'h1C);
    embed = 1'b0;
    l = cp.lst_cnt;
    fld();
    wlk(30);
    `CHK("lst runs", 1'b1, cp.lst_cnt > l)
    `CHK("qck off", 1'b0, QCK_ENABLE)
    QCK_FREE_RUN = 1'b1;
    wlk(10);
    `CHK("qck free", 1'b1, QCK_ENABLE)
    conclude();
  end
endmodule : test_seoc_top
bind seoc_top seoc_chk u_chk (.*);
